// ---- design/jifa_params.svh ----
// Purpose: constants for the jtag indirect flash access block
// Assumes: included by bare name
// Notes: instruction and operation codes are local choices
//
// Overview of operation
// - no boundary-scan cells; the device acts as a bypass element in a chain
// - four dedicated pins TCK, TMS, TDI and TDO, shared with nothing else
// - sixteen-bit instruction register decodes five instructions
// - instruction register defaults to BYPASS
// - BYPASS selects the single-bit bypass register between TDI and TDO
// - IDCODE selects the 32-bit device identity register
// - indirect access starts by shifting op code and payload; the instruction selects the register
// - poll op captures but never updates, so one-bit shifts suffice
// - read starts once just the two op code bits are shifted
// - write payload up to 18 bits, left-justified to bit 17
// - busy sits at bit 0, high from start until completion
// - commands while busy are ignored; a command is taken only from a scan that captured busy low
// - read result follows busy in 18 bits, right-justified
// - watchdog timer suspended while the processor is halted by debug
`ifndef JIFA_PARAMS_SVH
`define JIFA_PARAMS_SVH
`define JIFA_IR_W        16
`define JIFA_IR_BYPASS   16'hffff
`define JIFA_IR_IDCODE   16'h0004
`define JIFA_IR_FCTRL    16'h0082
`define JIFA_IR_FADDR    16'h0083
`define JIFA_IR_FDATA    16'h0084
`define JIFA_IR_FSCALE   16'h0085
`define JIFA_IR_CAPTURE  16'h0001
// identity value is arbitrary, bit 0 set as the standard demands
`define JIFA_IDCODE      32'h0a5a_0001
`define JIFA_OP_POLL     2'h0
`define JIFA_OP_READ     2'h1
`define JIFA_OP_WRITE    2'h2
`define JIFA_PAY_W       18
`define JIFA_PAY_MSB     17
`define JIFA_FCTRL_W     8
`define JIFA_FADDR_W     16
`define JIFA_FDATA_W     8
`define JIFA_FSCALE_W    8
`define JIFA_SEL_CTRL    2'h0
`define JIFA_SEL_ADDR    2'h1
`define JIFA_SEL_DATA    2'h2
`define JIFA_SEL_SCALE   2'h3
`define JIFA_OFS_STATUS  4'h0
`define JIFA_OFS_CONTROL 4'h4
`define JIFA_CONTROL_RST 1'b1
`endif

// ---- design/jifa_pkg.sv ----
// Purpose: types of the jtag indirect flash access block
// Assumes: nothing
// Notes: tap states are one-hot
package jifa_pkg;
   typedef enum logic [15:0] {
      ST_TLR    = 16'h0001,
      ST_RTI    = 16'h0002,
      ST_SEL_DR = 16'h0004,
      ST_CAP_DR = 16'h0008,
      ST_SH_DR  = 16'h0010,
      ST_EX1_DR = 16'h0020,
      ST_PA_DR  = 16'h0040,
      ST_EX2_DR = 16'h0080,
      ST_UPD_DR = 16'h0100,
      ST_SEL_IR = 16'h0200,
      ST_CAP_IR = 16'h0400,
      ST_SH_IR  = 16'h0800,
      ST_EX1_IR = 16'h1000,
      ST_PA_IR  = 16'h2000,
      ST_EX2_IR = 16'h4000,
      ST_UPD_IR = 16'h8000
   } jifa_tap_type;
endpackage

// ---- design/jifa_top.sv ----
// Purpose: test access port with bypass, identity and indirect flash registers
// Assumes: TCK domain owns the pins; CLK domain owns the flash registers
// Notes: commands cross by toggle handshake; fields stay stable while busy
`timescale 1ns/1ps
`include "jifa_params.svh"
module jifa_top
   import jifa_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        TCK,
   input  wire logic        TMS,
   input  wire logic        TDI,
   output logic             TDO,
   output logic             TDO_OE,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   input  wire logic        CPU_HALTED,
   output logic             WATCHDOG_SUSPEND,
   input  wire logic [7:0]  FLASH_RDATA,
   output logic             FLASH_RD_STB,
   output logic             FLASH_WR_STB,
   output logic      [7:0]  FLASH_CTRL,
   output logic      [15:0] FLASH_ADDR,
   output logic      [7:0]  FLASH_WDATA,
   output logic      [7:0]  FLASH_SCALE
);

   // tck domain
   jifa_tap_type st_q;
   jifa_tap_type st_d;
   logic [15:0]  ir_q;
   logic [15:0]  ir_sh_q;
   logic [31:0]  dr_q;
   logic [31:0]  dr_sh;
   logic         busy_cap_q;
   logic         req_tog_q;
   logic [1:0]   op_q;
   logic [1:0]   sel_q;
   logic [17:0]  pay_q;
   logic         done_s1_q;
   logic         done_s2_q;
   logic         tdo_q;
   logic         tdo_oe_q;
   // clk domain state read across by handshake
   logic         done_tog_q;
   logic [17:0]  result_q;

   always_comb begin
      case (st_q)
         ST_TLR:    st_d = TMS ? ST_TLR : ST_RTI;
         ST_RTI:    st_d = TMS ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: st_d = TMS ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: st_d = TMS ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  st_d = TMS ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: st_d = TMS ? ST_UPD_DR : ST_PA_DR;
         ST_PA_DR:  st_d = TMS ? ST_EX2_DR : ST_PA_DR;
         ST_EX2_DR: st_d = TMS ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: st_d = TMS ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: st_d = TMS ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: st_d = TMS ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  st_d = TMS ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: st_d = TMS ? ST_UPD_IR : ST_PA_IR;
         ST_PA_IR:  st_d = TMS ? ST_EX2_IR : ST_PA_IR;
         ST_EX2_IR: st_d = TMS ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: st_d = TMS ? ST_SEL_DR : ST_RTI;
         default:   st_d = ST_TLR;
      endcase
   end

   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         st_q <= ST_TLR;
      end else begin
         st_q <= st_d;
      end
   end

   // instruction decode; unknown codes fall back to bypass
   wire is_id   = (ir_q == `JIFA_IR_IDCODE);
   wire is_ctrl = (ir_q == `JIFA_IR_FCTRL);
   wire is_addr = (ir_q == `JIFA_IR_FADDR);
   wire is_data = (ir_q == `JIFA_IR_FDATA);
   wire is_scal = (ir_q == `JIFA_IR_FSCALE);
   wire is_ind  = is_ctrl | is_addr | is_data | is_scal;
   wire [1:0] sel_w = is_ctrl ? `JIFA_SEL_CTRL :
                      is_addr ? `JIFA_SEL_ADDR :
                      is_data ? `JIFA_SEL_DATA : `JIFA_SEL_SCALE;

   wire        busy    = req_tog_q ^ done_s2_q;
   wire [1:0]  in_op   = dr_q[19:18];
   wire [17:0] in_pay  = dr_q[17:0];
   wire        upd_dr  = (st_q == ST_UPD_DR);
   wire        launch  = upd_dr & is_ind & (in_op != `JIFA_OP_POLL) & !busy_cap_q;
   // result is only stable once busy has fallen
   wire [17:0] res_vis = busy ? 18'h0 : result_q;

   // shift path length follows the instruction
   assign dr_sh = is_id  ? {TDI, dr_q[31:1]} :
                  is_ind ? {12'h0, TDI, dr_q[19:1]} :
                           {31'h0, TDI};

   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         ir_q    <= `JIFA_IR_BYPASS;
         ir_sh_q <= 16'h0000;
      end else begin
         case (st_q)
            ST_TLR:    ir_q    <= `JIFA_IR_BYPASS;
            ST_CAP_IR: ir_sh_q <= `JIFA_IR_CAPTURE;
            ST_SH_IR:  ir_sh_q <= {TDI, ir_sh_q[15:1]};
            ST_UPD_IR: ir_q    <= ir_sh_q;
            default:   ir_q    <= ir_q;
         endcase
      end
   end

   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         dr_q       <= 32'h0000_0000;
         busy_cap_q <= 1'b0;
      end else if (st_q == ST_CAP_DR) begin
         busy_cap_q <= busy;
         if (is_id) begin
            dr_q <= `JIFA_IDCODE;
         end else if (is_ind) begin
            dr_q <= {13'h0, res_vis, busy};
         end else begin
            dr_q <= 32'h0000_0000;
         end
      end else if (st_q == ST_SH_DR) begin
         dr_q <= dr_sh;
      end
   end

   // command launch, held stable for the clk side until done returns
   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         req_tog_q <= 1'b0;
         op_q      <= `JIFA_OP_POLL;
         sel_q     <= `JIFA_SEL_CTRL;
         pay_q     <= 18'h0;
      end else if (launch) begin
         req_tog_q <= ~req_tog_q;
         op_q      <= in_op;
         sel_q     <= sel_w;
         pay_q     <= in_pay;
      end
   end

   always_ff @(posedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         done_s1_q <= 1'b0;
         done_s2_q <= 1'b0;
      end else begin
         done_s1_q <= done_tog_q;
         done_s2_q <= done_s1_q;
      end
   end

   // tdo changes on the falling edge as the standard asks
   always_ff @(negedge TCK or negedge RSTN) begin
      if (!RSTN) begin
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q    <= (st_q == ST_SH_IR) ? ir_sh_q[0] : dr_q[0];
         tdo_oe_q <= (st_q == ST_SH_IR) | (st_q == ST_SH_DR);
      end
   end

   assign TDO    = tdo_q;
   assign TDO_OE = tdo_oe_q;

   // clk domain
   logic                      req_s1_q;
   logic                      req_s2_q;
   logic                      req_s3_q;
   logic [`JIFA_FCTRL_W-1:0]  fctrl_q;
   logic [`JIFA_FADDR_W-1:0]  faddr_q;
   logic [`JIFA_FDATA_W-1:0]  fdata_q;
   logic [`JIFA_FSCALE_W-1:0] fscale_q;
   logic                      rd_stb_q;
   logic                      wr_stb_q;
   logic                      wdog_en_q;
   logic [31:0]               rdata_q;

   wire go     = req_s2_q ^ req_s3_q;
   wire go_rd  = go & (op_q == `JIFA_OP_READ);
   wire go_wr  = go & (op_q == `JIFA_OP_WRITE);
   wire sel_dt = (sel_q == `JIFA_SEL_DATA);

   // write payload is left-justified; read result is right-justified
   wire [17:0] rd_mux =
      (sel_q == `JIFA_SEL_CTRL) ? {10'h0, fctrl_q} :
      (sel_q == `JIFA_SEL_ADDR) ? {2'h0, faddr_q} :
      (sel_q == `JIFA_SEL_DATA) ? {10'h0, FLASH_RDATA} :
                                  {10'h0, fscale_q};

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
      end else begin
         req_s1_q <= req_tog_q;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         fctrl_q  <= 8'h00;
         faddr_q  <= 16'h0000;
         fdata_q  <= 8'h00;
         fscale_q <= 8'h00;
      end else if (go_wr) begin
         case (sel_q)
            `JIFA_SEL_CTRL: fctrl_q  <= pay_q[17:10];
            `JIFA_SEL_ADDR: faddr_q  <= pay_q[17:2];
            `JIFA_SEL_DATA: fdata_q  <= pay_q[17:10];
            default:        fscale_q <= pay_q[17:10];
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         result_q   <= 18'h0;
         done_tog_q <= 1'b0;
         rd_stb_q   <= 1'b0;
         wr_stb_q   <= 1'b0;
      end else begin
         rd_stb_q <= go_rd & sel_dt;
         wr_stb_q <= go_wr & sel_dt;
         if (go_rd) begin
            result_q <= rd_mux;
         end
         if (go) begin
            done_tog_q <= ~done_tog_q;
         end
      end
   end

   assign FLASH_RD_STB = rd_stb_q;
   assign FLASH_WR_STB = wr_stb_q;
   assign FLASH_CTRL   = fctrl_q;
   assign FLASH_ADDR   = faddr_q;
   assign FLASH_WDATA  = fdata_q;
   assign FLASH_SCALE  = fscale_q;

   // register port: control steers watchdog suspension, status shows halt
   wire ctl_hit = (REG_ADDR == `JIFA_OFS_CONTROL);
   wire sts_hit = (REG_ADDR == `JIFA_OFS_STATUS);
   wire [31:0] rd_word =
      sts_hit ? {30'h0, WATCHDOG_SUSPEND, CPU_HALTED} :
      ctl_hit ? {31'h0, wdog_en_q} : 32'h0000_0000;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wdog_en_q <= `JIFA_CONTROL_RST;
         rdata_q  <= 32'h0000_0000;
      end else begin
         if (REG_WR && ctl_hit) begin
            wdog_en_q <= REG_WDATA[0];
         end
         rdata_q <= REG_RD ? rd_word : 32'h0000_0000;
      end
   end

   assign REG_RDATA   = rdata_q;
   assign WATCHDOG_SUSPEND = CPU_HALTED & wdog_en_q;

   // checks
   property p_tlr_five;
      @(posedge TCK) disable iff (!RSTN)
      TMS[*5] |=> st_q == ST_TLR;
   endproperty
   a_tlr_five: assert property (p_tlr_five) else $error("five tms high did not reset tap");

   property p_ir_default;
      @(posedge TCK) disable iff (!RSTN)
      st_q == ST_TLR |=> ir_q == `JIFA_IR_BYPASS;
   endproperty
   a_ir_default: assert property (p_ir_default) else $error("ir not bypass after reset");

   property p_bypass_zero;
      @(posedge TCK) disable iff (!RSTN)
      (st_q == ST_CAP_DR) && !is_id && !is_ind |=> dr_q == 32'h0000_0000;
   endproperty
   a_bypass_zero: assert property (p_bypass_zero) else $error("bypass capture not zero");

   property p_idcode;
      @(posedge TCK) disable iff (!RSTN)
      (st_q == ST_CAP_DR) && is_id |=> dr_q == `JIFA_IDCODE;
   endproperty
   a_idcode: assert property (p_idcode) else $error("identity capture wrong");

   property p_busy_bit0;
      @(posedge TCK) disable iff (!RSTN)
      (st_q == ST_CAP_DR) && is_ind |=> dr_q[0] == $past(busy) && busy_cap_q == dr_q[0];
   endproperty
   a_busy_bit0: assert property (p_busy_bit0) else $error("busy not at bit 0");

   property p_poll_quiet;
      @(posedge TCK) disable iff (!RSTN)
      upd_dr && (in_op == `JIFA_OP_POLL) |=> $stable(req_tog_q);
   endproperty
   a_poll_quiet: assert property (p_poll_quiet) else $error("poll launched an operation");

   property p_busy_ignore;
      @(posedge TCK) disable iff (!RSTN)
      upd_dr && busy_cap_q |=> $stable(req_tog_q) && $stable(pay_q);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("command taken while busy");

   property p_read_start;
      @(posedge TCK) disable iff (!RSTN)
      upd_dr && is_ind && !busy_cap_q && (in_op == `JIFA_OP_READ) |=> busy && op_q == `JIFA_OP_READ;
   endproperty
   a_read_start: assert property (p_read_start) else $error("read did not start");

   property p_done_toggle;
      @(posedge CLK) disable iff (!RSTN)
      go |=> done_tog_q != $past(done_tog_q);
   endproperty
   a_done_toggle: assert property (p_done_toggle) else $error("operation did not complete");

   property p_wdog_halt;
      @(posedge CLK) disable iff (!RSTN)
      CPU_HALTED && wdog_en_q |-> WATCHDOG_SUSPEND;
   endproperty
   a_wdog_halt: assert property (p_wdog_halt) else $error("watchdog running while halted");

   property p_wdog_run;
      @(posedge CLK) disable iff (!RSTN)
      !CPU_HALTED |-> !WATCHDOG_SUSPEND;
   endproperty
   a_wdog_run: assert property (p_wdog_run) else $error("watchdog suspended while running");

   property p_oe_shift;
      @(posedge TCK) disable iff (!RSTN)
      TDO_OE == ((st_q == ST_SH_IR) || (st_q == ST_SH_DR));
   endproperty
   a_oe_shift: assert property (p_oe_shift) else $error("data out enable outside shift");

   property p_bypass_shift;
      @(posedge TCK) disable iff (!RSTN)
      (st_q == ST_SH_DR) && !is_id && !is_ind |=> dr_q == {31'h0, $past(TDI)};
   endproperty
   a_bypass_shift: assert property (p_bypass_shift) else $error("bypass path not one bit");

   property p_ir_capture;
      @(posedge TCK) disable iff (!RSTN)
      st_q == ST_CAP_IR |=> ir_sh_q == `JIFA_IR_CAPTURE;
   endproperty
   a_ir_capture: assert property (p_ir_capture) else $error("instruction capture wrong");

   property p_ir_update;
      @(posedge TCK) disable iff (!RSTN)
      st_q == ST_UPD_IR |=> ir_q == $past(ir_sh_q);
   endproperty
   a_ir_update: assert property (p_ir_update) else $error("instruction update lost");

   property p_wr_land;
      @(posedge CLK) disable iff (!RSTN)
      go_wr && sel_dt |=> FLASH_WR_STB && (FLASH_WDATA == pay_q[17:10]);
   endproperty
   a_wr_land: assert property (p_wr_land) else $error("data write not left justified");

   property p_rd_result;
      @(posedge CLK) disable iff (!RSTN)
      go_rd |=> result_q == $past(rd_mux);
   endproperty
   a_rd_result: assert property (p_rd_result) else $error("read result not taken");

endmodule // jifa_top

// ---- testbench/jifa_host_model.sv ----
// Purpose: behavioural jtag programmer driving the test access port
// Assumes: tck period 12 ns; tck stands still low between frames
// Notes: scan tasks are called from the bench; tdo sampled on rising tck
`timescale 1ns/1ps
module jifa_host_model (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   logic oe_seen;
   logic oe_shift;

   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one test clock: pins change while tck is low, tdo taken at the rise
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #6 tck = 1'b1;
      o = tdo;
      oe_seen = tdo_oe;
      #6 tck = 1'b0;
   endtask

   task automatic reset_tap();
      logic o;
      repeat (5) tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
   endtask

   // from idle: ir or dr scan of n bits lsb first, then update and back to idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic o;
      dout = 32'h0;
      oe_shift = 1'b1;
      tick(1'b1, 1'b0, o);
      if (ir) tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
      tick(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         tick(logic'(i == n - 1), din[i], o);
         dout[i] = o;
         oe_shift = oe_shift & oe_seen;
      end
      // update and idle ticks show the inverse of the last bit, never a stale value
      tick(1'b1, ~din[n - 1], o);
      tick(1'b0, ~din[n - 1], o);
   endtask
endmodule // jifa_host_model

// ---- testbench/jifa_top_tb.sv ----
// Purpose: self-checking bench for the jtag indirect flash access block
// Assumes: host model owns the jtag pins; bench owns the register port
// Notes: write and read of every indirect register, busy refusal, bypass
`timescale 1ns/1ps
`include "jifa_params.svh"
module jifa_top_tb;
   logic        clk, rstn, tck, tms, tdi, tdo, tdo_oe, reg_wr, reg_rd, cpu_halted, wdog_suspend;
   logic        flash_rd_stb, flash_wr_stb;
   logic [3:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, dout, v;
   logic [7:0]  flash_rdata, flash_ctrl, flash_wdata, flash_scale;
   logic [15:0] flash_addr;
   int          err_total, total_checks, wr_cnt, rd_cnt;
   logic [15:0] irs [4] = '{`JIFA_IR_FCTRL, `JIFA_IR_FADDR, `JIFA_IR_FDATA, `JIFA_IR_FSCALE};
   int          wid [4] = '{8, 16, 8, 8};
   logic [31:0] vals [4] = '{32'h5a, 32'hbeef, 32'ha5, 32'h0f};
   logic [31:0] rexp [4] = '{32'h5a, 32'hbeef, 32'h3c, 32'h0f};

   jifa_host_model host_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
   jifa_top dut_u (.CLK(clk), .RSTN(rstn), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .CPU_HALTED(cpu_halted), .WATCHDOG_SUSPEND(wdog_suspend), .FLASH_RDATA(flash_rdata),
      .FLASH_RD_STB(flash_rd_stb), .FLASH_WR_STB(flash_wr_stb), .FLASH_CTRL(flash_ctrl),
      .FLASH_ADDR(flash_addr), .FLASH_WDATA(flash_wdata), .FLASH_SCALE(flash_scale));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      if (flash_wr_stb === 1'b1) wr_cnt++;
      if (flash_rd_stb === 1'b1) rd_cnt++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (err_total == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      d = reg_rdata;
   endtask

   task automatic load_ir(input logic [15:0] code);
      host_u.scan(1'b1, 16, {16'h0, code}, dout);
      check(dout[15:0], 16'h0001);
   endtask

   // polls with single-bit scans until busy reads low
   task automatic poll();
      dout = 32'h1;
      for (int i = 0; i < 300 && dout[0] !== 1'b0; i++) host_u.scan(1'b0, 1, 32'h0, dout);
      check(dout[0], 1'b0);
   endtask

   initial begin
      #3_000_000;
      err_total++;
      results();
   end

   initial begin
      {rstn, reg_wr, reg_rd, cpu_halted, reg_addr, reg_wdata} = '0;
      flash_rdata = 8'h3c;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      cpu_halted <= 1'b1;
      reg_read(4'h4, v);
      check(v, 32'h1);
      reg_read(4'h0, v);
      check(v, 32'h3);
      check(wdog_suspend, 1'b1);
      reg_write(4'h4, 32'h0);
      reg_read(4'h0, v);
      check(v, 32'h1);
      check(wdog_suspend, 1'b0);
      reg_read(4'h8, v);
      check(v, 32'h0);
      host_u.reset_tap();
      host_u.scan(1'b0, 2, 32'h3, dout);
      check(dout[1:0], 2'b10);
      load_ir(`JIFA_IR_IDCODE);
      host_u.scan(1'b0, 32, 32'h0, dout);
      check(dout, `JIFA_IDCODE);
      check(host_u.oe_shift, 1'b1);
      check(host_u.oe_seen, 1'b0);
      host_u.reset_tap();
      host_u.scan(1'b0, 2, 32'h3, dout);
      check(dout[1:0], 2'b10);
      load_ir(16'h1234);
      host_u.scan(1'b0, 2, 32'h3, dout);
      check(dout[1:0], 2'b10);
      for (int k = 0; k < 4; k++) begin
         load_ir(irs[k]);
         host_u.scan(1'b0, wid[k] + 2, (32'h2 << wid[k]) | vals[k], dout);
         poll();
      end
      check(flash_ctrl, 8'h5a);
      check(flash_addr, 16'hbeef);
      check(flash_wdata, 8'ha5);
      check(flash_scale, 8'h0f);
      check(wr_cnt, 1);
      for (int k = 0; k < 4; k++) begin
         load_ir(irs[k]);
         host_u.scan(1'b0, 2, 32'h1, dout);
         poll();
         host_u.scan(1'b0, wid[k] + 1, 32'h0, dout);
         check(dout, rexp[k] << 1);
      end
      check(rd_cnt, 1);
      load_ir(`JIFA_IR_FDATA);
      host_u.scan(1'b0, 10, 32'h211, dout);
      host_u.scan(1'b0, 10, 32'h222, dout);
      check(dout[0], 1'b1);
      for (int i = 0; i < 300 && dout[0] !== 1'b0; i++) host_u.scan(1'b0, 10, 32'h222, dout);
      poll();
      check(flash_wdata, 8'h22);
      check(wr_cnt, 3);
      host_u.scan(1'b0, 20, 32'h3fc00, dout);
      repeat (10) @(posedge clk);
      check(flash_wdata, 8'h22);
      check(wr_cnt, 3);
      host_u.scan(1'b0, 1, 32'h0, dout);
      check(dout[0], 1'b0);
      host_u.scan(1'b0, 2, 32'h3, dout);
      host_u.scan(1'b0, 1, 32'h0, dout);
      check(dout[0], 1'b1);
      poll();
      check(wr_cnt, 3);
      check(rd_cnt, 1);
      results();
   end
endmodule // jifa_top_tb
